// ===== rtl/acc_pkg.sv
// Package with register map, field layout, reset values and types of the converter control block.
package acc_pkg;

  // ****************************************************************
  // Register offsets on the plain register port.
  // ****************************************************************
  localparam logic [7:0] OFS_MODE    = 8'h10;
  localparam logic [7:0] OFS_CLKFLAG = 8'h11;
  localparam logic [7:0] OFS_RESHI   = 8'h12;
  localparam logic [7:0] OFS_REFSEL  = 8'h13;
  localparam logic [7:0] OFS_SAMPRES = 8'h14;
  localparam logic [7:0] OFS_PINSEL  = 8'h16;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int BIT_EN    = 7;
  localparam int BIT_START = 6;
  localparam int BIT_EOC   = 5;
  localparam int BIT_GATE  = 4;
  localparam int BIT_FLAG  = 7;
  localparam int BIT_IE    = 6;
  localparam int BIT_EXT   = 7;

  // ****************************************************************
  // Reset values of the writable fields and of the end-of-conversion status.
  // ****************************************************************
  localparam logic       RST_EN    = 1'b0;
  localparam logic       RST_EOC   = 1'b1;
  localparam logic [1:0] RST_LEVEL = 2'h3;
  localparam logic [1:0] RST_SAMPW = 2'h2;
  localparam logic [1:0] RST_RES   = 2'h2;

  // ****************************************************************
  // Conversion clock ratios, channel codes and resolution codes.
  // ****************************************************************
  localparam logic [4:0] DIV_SEL0 = 5'h10;
  localparam logic [4:0] DIV_SEL1 = 5'h08;
  localparam logic [4:0] DIV_SEL2 = 5'h01;
  localparam logic [4:0] DIV_SEL3 = 5'h02;
  localparam logic [3:0] CHAN_LAST = 4'hC;
  localparam int         CHAN_N    = 13;
  localparam logic [1:0] RES_8     = 2'h0;
  localparam logic [1:0] RES_10    = 2'h1;
  localparam logic [3:0] LSB_8     = 4'h4;
  localparam logic [3:0] LSB_10    = 4'h2;
  localparam logic [3:0] LSB_12    = 4'h0;
  localparam logic [3:0] MSB_IDX   = 4'hB;
  // Least clocks per bit step before the decision clock: one for the trial flop, two for the comparator synchroniser.
  localparam logic [1:0] STEP_MIN  = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_DONE} acc_state_t;

  // Controls handed to the analog converter core and pads.
  typedef struct packed {
    logic                power_en;
    logic [CHAN_N-1:0]   chan_connect;
    logic                ref_external;
    logic [1:0]          ref_level;
    logic                sample;
    logic                conv_tick;
    logic [11:0]         trial;
  } acc_analog_t;

endpackage

// ===== rtl/acc_clkdiv.sv
// Conversion clock divider that turns the instruction clock into one-cycle ticks.
`timescale 1ns/1ps
`default_nettype none
module acc_clkdiv (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            tick
);

  logic [3:0] cnt_reg;
  logic [4:0] ratio;
  logic [3:0] reload;

  // Ratio decode: 00 by 16, 01 by 8, 10 by 1, 11 by 2.
  assign ratio  = (sel == 2'h0) ? acc_pkg::DIV_SEL0 :
                  (sel == 2'h1) ? acc_pkg::DIV_SEL1 :
                  (sel == 2'h2) ? acc_pkg::DIV_SEL2 : acc_pkg::DIV_SEL3;
  assign reload = 4'(ratio - 5'h01);

  // Down counter; a select change takes effect at the next reload, so a tick is never split.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 4'h0;
      tick    <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 4'h0;
      tick    <= 1'b0;
    end else begin
      tick    <= (cnt_reg == 4'h0);
      cnt_reg <= (cnt_reg == 4'h0) ? reload : cnt_reg - 4'h1;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/acc_top.sv
// Converter control block: registers, conversion sequencer, result and interrupt logic.
`timescale 1ns/1ps
`default_nettype none

module acc_top (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  input  wire logic            cmp_in,
  output acc_pkg::acc_analog_t analog_ctrl,
  output logic [4:0]           pa_digital_off,
  output logic [5:0]           pb_digital_off,
  output logic                 irq
);

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic                en_reg;
  logic                gate_reg;
  logic [3:0]          chan_sel_reg;
  logic                eoc_reg;
  logic                flag_reg;
  logic                ie_reg;
  logic [1:0]          ck_reg;
  logic [11:0]         result_reg;
  logic                ext_reg;
  logic [1:0]          level_reg;
  logic [2:0]          pbhi_reg;
  logic [1:0]          samp_w_reg;
  logic [1:0]          res_reg;
  logic [4:0]          paan_reg;
  logic [2:0]          pblo_reg;

  // ****************************************************************
  // Sequencer state.
  // ****************************************************************
  acc_pkg::acc_state_t state_reg;
  acc_pkg::acc_state_t state_next;
  logic [11:0]         sar_reg;
  logic [3:0]          bit_idx_reg;
  logic [1:0]          step_cnt_reg;
  logic [3:0]          samp_cnt_reg;
  logic                cmp_meta_reg;
  logic                cmp_sync_reg;
  logic                tick;

  // ****************************************************************
  // Register port decode.
  // ****************************************************************
  logic wr_mode;
  logic wr_clkflag;
  logic wr_refsel;
  logic wr_sampres;
  logic wr_pinsel;
  logic start_ok;
  logic flag_set;
  logic flag_clr;

  // Address decode; start is only taken from idle with the converter enabled by the same write.
  assign wr_mode    = reg_wr && (reg_addr == acc_pkg::OFS_MODE);
  assign wr_clkflag = reg_wr && (reg_addr == acc_pkg::OFS_CLKFLAG);
  assign wr_refsel  = reg_wr && (reg_addr == acc_pkg::OFS_REFSEL);
  assign wr_sampres = reg_wr && (reg_addr == acc_pkg::OFS_SAMPRES);
  assign wr_pinsel  = reg_wr && (reg_addr == acc_pkg::OFS_PINSEL);
  assign start_ok   = wr_mode && reg_wdata[acc_pkg::BIT_START] && reg_wdata[acc_pkg::BIT_EN]
                      && (state_reg == acc_pkg::ST_IDLE);
  assign flag_set   = (state_reg == acc_pkg::ST_DONE);
  assign flag_clr   = wr_clkflag && !reg_wdata[acc_pkg::BIT_FLAG];

  // ****************************************************************
  // Conversion arithmetic.
  // ****************************************************************
  logic [3:0]  samp_len;
  logic [3:0]  lsb_idx;
  logic [11:0] bit_mask;
  logic [11:0] trial;
  logic [11:0] sar_keep;
  logic        samp_end;
  logic        step_end;
  logic        last_bit;

  // Sample width in conversion clocks.
  assign samp_len = 4'h1 << samp_w_reg;
  // Lowest bit decided; lower bits stay zero so short results sit left aligned.
  assign lsb_idx  = (res_reg == acc_pkg::RES_8)  ? acc_pkg::LSB_8 :
                    (res_reg == acc_pkg::RES_10) ? acc_pkg::LSB_10 : acc_pkg::LSB_12;
  assign bit_mask = 12'h001 << bit_idx_reg;
  assign trial    = sar_reg | bit_mask;
  assign sar_keep = cmp_sync_reg ? trial : sar_reg;
  assign samp_end = (state_reg == acc_pkg::ST_SAMPLE) && tick && (samp_cnt_reg + 4'h1 == samp_len);
  // A bit step needs a conversion tick and enough cycles for the comparator to settle and sync.
  assign step_end = (state_reg == acc_pkg::ST_CONVERT) && tick && (step_cnt_reg == acc_pkg::STEP_MIN);
  assign last_bit = (bit_idx_reg == lsb_idx);

  // ****************************************************************
  // Conversion clock divider, stopped while the converter is off.
  // ****************************************************************
  acc_clkdiv u_clkdiv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (en_reg),
    .sel     (ck_reg),
    .tick    (tick)
  );

  // Comparator comes from the analog core, so it passes two flops before use.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= cmp_in;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // Sequencer next state; clearing enable aborts a conversion at once.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      acc_pkg::ST_IDLE:    if (start_ok) state_next = acc_pkg::ST_SAMPLE;
      acc_pkg::ST_SAMPLE:  if (samp_end) state_next = acc_pkg::ST_CONVERT;
      acc_pkg::ST_CONVERT: if (step_end && last_bit) state_next = acc_pkg::ST_DONE;
      acc_pkg::ST_DONE:    state_next = acc_pkg::ST_IDLE;
      default:             state_next = acc_pkg::ST_IDLE;
    endcase
    if (!en_reg && (state_reg != acc_pkg::ST_IDLE)) begin
      state_next = acc_pkg::ST_IDLE;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= acc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sample counter counts conversion ticks of the sampling pulse.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_cnt_reg <= 4'h0;
    end else if (state_reg != acc_pkg::ST_SAMPLE) begin
      samp_cnt_reg <= 4'h0;
    end else if (tick) begin
      samp_cnt_reg <= samp_cnt_reg + 4'h1;
    end
  end

  // Successive approximation: try each bit from the top, keep it if the comparator says so.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sar_reg      <= 12'h000;
      bit_idx_reg  <= acc_pkg::MSB_IDX;
      step_cnt_reg <= 2'h0;
    end else if (state_reg != acc_pkg::ST_CONVERT) begin
      sar_reg      <= 12'h000;
      bit_idx_reg  <= acc_pkg::MSB_IDX;
      step_cnt_reg <= 2'h0;
    end else if (step_end) begin
      sar_reg      <= sar_keep;
      bit_idx_reg  <= bit_idx_reg - 4'h1;
      step_cnt_reg <= 2'h0;
    end else if (step_cnt_reg != acc_pkg::STEP_MIN) begin
      step_cnt_reg <= step_cnt_reg + 2'h1;
    end
  end

  // Result registers load on the last bit, one cycle before status and flag rise.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_reg <= 12'h000;
    end else if (step_end && last_bit) begin
      result_reg <= sar_keep;
    end
  end

  // End-of-conversion status: cleared by an accepted start, set in the done cycle.
  // An abort by disabling leaves it low until the next completed conversion.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      eoc_reg <= acc_pkg::RST_EOC;
    end else if (start_ok) begin
      eoc_reg <= 1'b0;
    end else if (flag_set) begin
      eoc_reg <= 1'b1;
    end
  end

  // Interrupt flag: the set wins over a firmware clear in the same cycle; writing one does nothing.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_set | (flag_reg & ~flag_clr);
    end
  end

  // Mode register fields.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_reg       <= acc_pkg::RST_EN;
      gate_reg     <= 1'b0;
      chan_sel_reg <= 4'h0;
    end else if (wr_mode) begin
      en_reg       <= reg_wdata[acc_pkg::BIT_EN];
      gate_reg     <= reg_wdata[acc_pkg::BIT_GATE];
      chan_sel_reg <= reg_wdata[3:0];
    end
  end

  // Clock and enable fields of the flag register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ie_reg <= 1'b0;
      ck_reg <= 2'h0;
    end else if (wr_clkflag) begin
      ie_reg <= reg_wdata[acc_pkg::BIT_IE];
      ck_reg <= reg_wdata[5:4];
    end
  end

  // Reference select register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_reg   <= 1'b0;
      level_reg <= acc_pkg::RST_LEVEL;
    end else if (wr_refsel) begin
      ext_reg   <= reg_wdata[acc_pkg::BIT_EXT];
      level_reg <= reg_wdata[1:0];
    end
  end

  // Sampling and resolution register; fields change mid-conversion at the user's risk.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pbhi_reg   <= 3'h0;
      samp_w_reg <= acc_pkg::RST_SAMPW;
      res_reg    <= acc_pkg::RST_RES;
    end else if (wr_sampres) begin
      pbhi_reg   <= reg_wdata[6:4];
      samp_w_reg <= reg_wdata[3:2];
      res_reg    <= reg_wdata[1:0];
    end
  end

  // Analog pin select register for the lower pins.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      paan_reg <= 5'h00;
      pblo_reg <= 3'h0;
    end else if (wr_pinsel) begin
      paan_reg <= reg_wdata[4:0];
      pblo_reg <= reg_wdata[7:5];
    end
  end

  // ****************************************************************
  // Read path.
  // ****************************************************************
  logic [7:0] rd_mux;

  // Start always reads zero; unmapped addresses read zero.
  assign rd_mux = (reg_addr == acc_pkg::OFS_MODE)    ? {en_reg, 1'b0, eoc_reg, gate_reg, chan_sel_reg} :
                  (reg_addr == acc_pkg::OFS_CLKFLAG) ? {flag_reg, ie_reg, ck_reg, result_reg[3:0]} :
                  (reg_addr == acc_pkg::OFS_RESHI)   ? result_reg[11:4] :
                  (reg_addr == acc_pkg::OFS_REFSEL)  ? {ext_reg, 5'h00, level_reg} :
                  (reg_addr == acc_pkg::OFS_SAMPRES) ? {1'b0, pbhi_reg, samp_w_reg, res_reg} :
                  (reg_addr == acc_pkg::OFS_PINSEL)  ? {pblo_reg, paan_reg} : 8'h00;

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ****************************************************************
  // Outputs to the analog side and the core.
  // ****************************************************************
  logic [acc_pkg::CHAN_N-1:0] chan_onehot;

  // Out-of-range channel codes connect nothing.
  assign chan_onehot = (gate_reg && (chan_sel_reg <= acc_pkg::CHAN_LAST)) ?
                       (acc_pkg::CHAN_N'(1) << chan_sel_reg) : '0;

  // Every output is a flop, so the pads see no decode glitches.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      analog_ctrl    <= '0;
      pa_digital_off <= 5'h00;
      pb_digital_off <= 6'h00;
      irq            <= 1'b0;
    end else begin
      analog_ctrl.power_en     <= en_reg;
      analog_ctrl.chan_connect <= chan_onehot;
      analog_ctrl.ref_external <= ext_reg;
      analog_ctrl.ref_level    <= level_reg;
      analog_ctrl.sample       <= (state_reg == acc_pkg::ST_SAMPLE);
      analog_ctrl.conv_tick    <= tick;
      analog_ctrl.trial        <= (state_reg == acc_pkg::ST_CONVERT) ? trial : 12'h000;
      pa_digital_off           <= paan_reg;
      pb_digital_off           <= {pbhi_reg, pblo_reg};
      irq                      <= flag_reg & ie_reg;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_start_reads_zero: assert property (reg_rd && reg_addr == acc_pkg::OFS_MODE |=> !reg_rdata[acc_pkg::BIT_START])
    else $error("start bit read back as one");
  a_eoc_start_clear: assert property (start_ok |=> !eoc_reg ##1 !eoc_reg)
    else $error("status not low after start");
  a_done_order: assert property ($rose(eoc_reg) |-> flag_reg && $past(result_reg) == result_reg)
    else $error("status rose before result or without flag");
  a_flag_sticky: assert property (flag_reg && !flag_clr |=> flag_reg)
    else $error("flag dropped without firmware clear");
  a_irq_masked: assert property (!ie_reg |=> !irq)
    else $error("interrupt passed while disabled");
  a_gate_off: assert property (!gate_reg |=> analog_ctrl.chan_connect == '0)
    else $error("channel connected with gate off");
  a_power_follow: assert property (analog_ctrl.power_en == $past(en_reg))
    else $error("power does not follow enable");
  a_left_align: assert property ($rose(eoc_reg) && res_reg == acc_pkg::RES_8 |-> result_reg[3:0] == 4'h0)
    else $error("8-bit result not left aligned");
  a_left_align_ten: assert property ($rose(eoc_reg) && res_reg == acc_pkg::RES_10 |-> result_reg[1:0] == 2'h0)
    else $error("10-bit result not left aligned");
  a_eoc_busy: assert property (state_reg == acc_pkg::ST_CONVERT |-> !eoc_reg)
    else $error("status high during conversion");

endmodule
`default_nettype wire

// ===== test/acc_cmp_model.sv
// Behavioural comparator and input pad standing at the far side of the converter control.
`timescale 1ns/1ps
`default_nettype none
module acc_cmp_model (
  input  wire logic                 clk,
  input  wire acc_pkg::acc_analog_t ctrl,
  input  wire logic [11:0]          level,
  output logic                      cmp_out
);
  logic toggle_reg = 1'b0;

  // An idle comparator gives no real answer; a changing pattern keeps a stale value from passing.
  // A plain process is used so the start value and the clocked update do not count as two drivers.
  always @(posedge clk) begin
    toggle_reg <= ~toggle_reg;
  end

  // High while the held input is at or above the trial code, if powered and connected.
  assign cmp_out = (ctrl.power_en && (ctrl.chan_connect != '0)) ? (level >= ctrl.trial) : toggle_reg;
endmodule
`default_nettype wire

// ===== test/acc_top_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb;
  // ****************************************************************
  // Signals and instances.
  // ****************************************************************
  logic                 clk;
  logic                 sys_rst;
  logic [7:0]           reg_addr;
  logic [7:0]           reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [7:0]           reg_rdata;
  logic                 cmp_in;
  acc_pkg::acc_analog_t analog_ctrl;
  logic [4:0]           pa_digital_off;
  logic [5:0]           pb_digital_off;
  logic                 irq;
  logic [11:0]          level;
  logic [7:0]           rv;
  logic [11:0]          res;
  int                   n;
  int                   fails;
  int                   compares;
  int                   samp_total;
  int                   samp_start;

  acc_top u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_in(cmp_in), .analog_ctrl(analog_ctrl),
    .pa_digital_off(pa_digital_off), .pb_digital_off(pb_digital_off), .irq(irq));
  acc_cmp_model u_cmp (.clk(clk), .ctrl(analog_ctrl), .level(level), .cmp_out(cmp_in));

  // Clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts clocks with the sample pulse high, so each conversion can check its width.
  always @(posedge clk) begin
    if (sys_rst) begin
      samp_total <= 0;
    end else if (analog_ctrl.sample) begin
      samp_total <= samp_total + 1;
    end
  end

  // ****************************************************************
  // Bus tasks and comparisons.
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t port value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk8(d, exp);
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Polls the status bit; a conversion that never ends counts as a mismatch.
  task automatic wait_eoc();
    n  = 0;
    rv = 8'h00;
    while (rv[5] !== 1'b1) begin
      rd(acc_pkg::OFS_MODE, rv);
      n++;
      if (n > 200) begin
        fails++;
        report_and_stop();
      end
    end
  endtask

  // Measures clocks between two ticks; the first tick after a select change may be short.
  task automatic tick_gap(output int g);
    g = 0;
    do begin settle(); g++; end while (analog_ctrl.conv_tick !== 1'b1 && g < 40);
    g = 0;
    do begin settle(); g++; end while (analog_ctrl.conv_tick !== 1'b1 && g < 40);
    if (g >= 40) begin
      fails++;
      report_and_stop();
    end
  endtask

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    level     = 12'hA5E;
    fails     = 0;
    compares  = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(acc_pkg::OFS_MODE, 8'h20);
    rdchk(acc_pkg::OFS_CLKFLAG, 8'h00);
    rdchk(acc_pkg::OFS_RESHI, 8'h00);
    rdchk(acc_pkg::OFS_REFSEL, 8'h03);
    rdchk(acc_pkg::OFS_SAMPRES, 8'h0A);
    rdchk(acc_pkg::OFS_PINSEL, 8'h00);
    wr(acc_pkg::OFS_RESHI, 8'hFF);
    wr(8'h15, 8'hFF);
    rdchk(acc_pkg::OFS_RESHI, 8'h00);
    rdchk(8'h15, 8'h00);
    $display("Test reset and access done");
    for (int c = 0; c < 13; c++) begin
      wr(acc_pkg::OFS_MODE, 8'h90 | 8'(c));
      settle();
      chk16(16'(analog_ctrl.chan_connect), 16'(13'h1 << c));
      chk16(16'(analog_ctrl.power_en), 16'h1);
    end
    wr(acc_pkg::OFS_MODE, 8'h85);
    settle();
    chk16(16'(analog_ctrl.chan_connect), 16'h0);
    wr(acc_pkg::OFS_MODE, 8'h15);
    settle();
    chk16(16'(analog_ctrl.power_en), 16'h0);
    $display("Test channel select done");
    for (int l = 0; l < 4; l++) begin
      wr(acc_pkg::OFS_REFSEL, {l[0], 5'h00, 2'(l)});
      settle();
      chk16(16'({analog_ctrl.ref_external, analog_ctrl.ref_level}), 16'({l[0], 2'(l)}));
      rdchk(acc_pkg::OFS_REFSEL, {l[0], 5'h00, 2'(l)});
    end
    wr(acc_pkg::OFS_SAMPRES, 8'h5A);
    wr(acc_pkg::OFS_PINSEL, 8'hA5);
    settle();
    chk16(16'({pb_digital_off, pa_digital_off}), 16'({6'h2D, 5'h05}));
    rdchk(acc_pkg::OFS_SAMPRES, 8'h5A);
    rdchk(acc_pkg::OFS_PINSEL, 8'hA5);
    $display("Test reference and pins done");
    for (int s = 0; s < 4; s++) begin
      wr(acc_pkg::OFS_CLKFLAG, {2'h0, 2'(s), 4'h0});
      wr(acc_pkg::OFS_MODE, 8'h80);
      tick_gap(n);
      chk16(16'(n), 16'(s == 0 ? 16 : s == 1 ? 8 : s == 2 ? 1 : 2));
    end
    $display("Test clock divider done");
    for (int r = 0; r < 4; r++) begin
      wr(acc_pkg::OFS_SAMPRES, {4'h0, 2'(r), 2'(r)});
      wr(acc_pkg::OFS_CLKFLAG, {1'b0, r != 3, 2'h2, 4'h0});
      samp_start = samp_total;
      wr(acc_pkg::OFS_MODE, 8'hD5);
      rdchk(acc_pkg::OFS_MODE, 8'h95);
      wait_eoc();
      chk16(16'(samp_total - samp_start), 16'(1 << r));
      res = level & (r == 0 ? 12'hFF0 : r == 1 ? 12'hFFC : 12'hFFF);
      rdchk(acc_pkg::OFS_RESHI, res[11:4]);
      rdchk(acc_pkg::OFS_CLKFLAG, {1'b1, r != 3, 2'h2, res[3:0]});
      chk16(16'(irq), 16'(r != 3));
      wr(acc_pkg::OFS_CLKFLAG, {1'b1, r != 3, 2'h2, 4'h0});
      rdchk(acc_pkg::OFS_CLKFLAG, {1'b1, r != 3, 2'h2, res[3:0]});
      wr(acc_pkg::OFS_CLKFLAG, 8'h20);
      settle();
      settle();
      chk16(16'(irq), 16'h0);
      rdchk(acc_pkg::OFS_CLKFLAG, {4'h2, res[3:0]});
    end
    $display("Test conversions done");
    wr(acc_pkg::OFS_MODE, 8'hD5);
    wr(acc_pkg::OFS_MODE, 8'h15);
    rdchk(acc_pkg::OFS_MODE, 8'h15);
    rdchk(acc_pkg::OFS_CLKFLAG, {4'h2, res[3:0]});
    rdchk(acc_pkg::OFS_RESHI, res[11:4]);
    wr(acc_pkg::OFS_MODE, 8'h45);
    rdchk(acc_pkg::OFS_MODE, 8'h05);
    $display("Test abort done");
    report_and_stop();
  end
endmodule
`default_nettype wire
